// ===== period_timer_pkg.sv
// Purpose: Shared constants for the period match timer
// Assumes: Register indices are local to this block's plain register port
// Notes:   Index values and the interrupt register layout are block-local
package period_timer_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] ADDR_COUNT   = 3'h0;
   localparam logic [2:0] ADDR_PERIOD  = 3'h1;
   localparam logic [2:0] ADDR_CONTROL = 3'h2;
   localparam logic [2:0] ADDR_FLAGS   = 3'h3;
   localparam logic [2:0] ADDR_ENABLES = 3'h4;

   // Control field positions
   localparam int CTL_PRE_LSB  = 0;
   localparam int CTL_RUN_BIT  = 2;
   localparam int CTL_POST_LSB = 3;
   localparam int CTL_POST_MSB = 6;

   // Interrupt bit position in flag and enable registers
   localparam int IRQ_MATCH_BIT = 1;

   // Reset values
   localparam logic [7:0] COUNT_RESET   = 8'h00;
   localparam logic [7:0] PERIOD_RESET  = 8'hff;
   localparam logic [6:0] CONTROL_RESET = 7'h00;

   // Prescale terminal counts: divide by 1, 4, 16
   localparam logic [3:0] PRE_TC_1  = 4'h0;
   localparam logic [3:0] PRE_TC_4  = 4'h3;
   localparam logic [3:0] PRE_TC_16 = 4'hf;
endpackage : period_timer_pkg

// ===== period_timer.sv
// Purpose: 8-bit period match timer with input prescaler and output postscaler
// Assumes: mclk is the instruction clock (100 MHz); rst is synchronous, active high
// Notes:   Registers sit behind a plain strobe port, read data valid one cycle later
//
// Functional notes
// - The block holds an 8-bit count register and an 8-bit period register.
// - While running, the count rises by one from zero on every prescaled instruction-clock tick.
// - While running, count and period are compared every cycle and equality on a prescaled tick gives the match output.
// - A match clears the count on the next prescaled tick and advances the postscaler.
// - Reset clears the count and sets the period to all ones.
// - Writes to count or control, and reset, clear both prescaler and postscaler.
// - Writing the control register leaves the count unchanged.
// - Control bit 2 turns the timer on when one and off when zero.
// - Postscale select N in control bits 6:3 gives a ratio of N+1 to one.
// - When the postscaler reaches the selected count the match interrupt flag is raised.
// - The flag is bit 1 of the flag register and requests an interrupt only with enable bit 1 set.
// - Count and period are readable and writable by software at any time.
// - The unscaled match goes out to the capture/compare/PWM units as their time base.
// - The match output also serves as an optional shift clock for the serial port.
// - Control bit 7 always reads zero and ignores writes.
//
// Implementation choices: the register addresses and strobed register access.
module period_timer #(
   parameter int COUNT_WIDTH = 8,   // Timer and period width
   parameter int POST_WIDTH  = 4    // Postscaler width
) (
   input  wire logic       mclk,       // Instruction clock
   input  wire logic       rst,        // Synchronous reset, active high
   input  wire logic [2:0] addr,       // Register index
   input  wire logic [7:0] wr_data,    // Write data
   input  wire logic       wr_en,      // Write strobe
   input  wire logic       rd_en,      // Read strobe
   output logic      [7:0] rd_data,    // Read data, cycle after rd_en
   output logic            match_out,  // Unscaled match pulse for PWM and serial port
   output logic            irq         // Level interrupt request
);
   logic [COUNT_WIDTH-1:0] count_q;
   logic [COUNT_WIDTH-1:0] period_q;
   logic [6:0]             control_q;
   logic [3:0]             pre_q;
   logic [POST_WIDTH-1:0]  post_q;
   logic                   flag_q;
   logic                   enable_q;
   logic                   tick;
   logic                   match;
   logic                   wr_count;
   logic                   wr_control;
   logic                   scaler_clr;
   logic                   post_done;

   // Terminal count of the input prescaler for a select code
   function automatic logic [3:0] pre_terminal(input logic [1:0] sel);
      if (sel[1]) begin
         pre_terminal = period_timer_pkg::PRE_TC_16;
      end else if (sel[0]) begin
         pre_terminal = period_timer_pkg::PRE_TC_4;
      end else begin
         pre_terminal = period_timer_pkg::PRE_TC_1;
      end
   endfunction

   // Write decodes
   assign wr_count   = wr_en && (addr == period_timer_pkg::ADDR_COUNT);
   assign wr_control = wr_en && (addr == period_timer_pkg::ADDR_CONTROL);
   assign scaler_clr = wr_count || wr_control;

   // A tick only while running, gated by the prescaler reaching its terminal count
   assign tick = control_q[period_timer_pkg::CTL_RUN_BIT] &&
                 (pre_q == pre_terminal(control_q[period_timer_pkg::CTL_PRE_LSB +: 2]));

   // Match only while running, so a stopped timer never fires
   assign match = control_q[period_timer_pkg::CTL_RUN_BIT] && (count_q == period_q);

   assign post_done = match &&
      (post_q == control_q[period_timer_pkg::CTL_POST_MSB:period_timer_pkg::CTL_POST_LSB]);

   // Input prescaler; cleared on count and control writes so the first period after setup is full length
   always_ff @(posedge mclk) begin
      if (rst || scaler_clr) begin
         pre_q <= 4'h0;
      end else if (control_q[period_timer_pkg::CTL_RUN_BIT]) begin
         if (tick) begin
            pre_q <= 4'h0;
         end else begin
            pre_q <= pre_q + 4'h1;
         end
      end
   end

   // Count register: software write wins over counting and match clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_q <= COUNT_WIDTH'(period_timer_pkg::COUNT_RESET);
      end else if (wr_count) begin
         count_q <= COUNT_WIDTH'(wr_data);
      end else if (match && tick) begin
         count_q <= '0;
      end else if (tick && !match) begin
         count_q <= count_q + COUNT_WIDTH'(1);
      end
   end

   // Period register
   always_ff @(posedge mclk) begin
      if (rst) begin
         period_q <= COUNT_WIDTH'(period_timer_pkg::PERIOD_RESET);
      end else if (wr_en && addr == period_timer_pkg::ADDR_PERIOD) begin
         period_q <= COUNT_WIDTH'(wr_data);
      end
   end

   // Control register; bit 7 is not stored
   always_ff @(posedge mclk) begin
      if (rst) begin
         control_q <= period_timer_pkg::CONTROL_RESET;
      end else if (wr_control) begin
         control_q <= wr_data[6:0];
      end
   end

   // Output postscaler, advanced on each match that ends a period
   always_ff @(posedge mclk) begin
      if (rst || scaler_clr) begin
         post_q <= '0;
      end else if (match && tick) begin
         if (post_done) begin
            post_q <= '0;
         end else begin
            post_q <= post_q + POST_WIDTH'(1);
         end
      end
   end

   // Match flag: a new event wins over a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (post_done && tick) begin
         flag_q <= 1'b1;
      end else if (wr_en && addr == period_timer_pkg::ADDR_FLAGS &&
                   wr_data[period_timer_pkg::IRQ_MATCH_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // Interrupt enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         enable_q <= 1'b0;
      end else if (wr_en && addr == period_timer_pkg::ADDR_ENABLES) begin
         enable_q <= wr_data[period_timer_pkg::IRQ_MATCH_BIT];
      end
   end

   // Registered outputs; irq follows the flag one cycle later
   always_ff @(posedge mclk) begin
      if (rst) begin
         match_out <= 1'b0;
         irq       <= 1'b0;
      end else begin
         match_out <= match && tick;
         irq       <= flag_q && enable_q;
      end
   end

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst || !rd_en) begin
         rd_data <= 8'h00;
      end else begin
         unique case (addr)
            period_timer_pkg::ADDR_COUNT:   rd_data <= 8'(count_q);
            period_timer_pkg::ADDR_PERIOD:  rd_data <= 8'(period_q);
            period_timer_pkg::ADDR_CONTROL: rd_data <= {1'b0, control_q};
            period_timer_pkg::ADDR_FLAGS:   rd_data <= 8'(flag_q) << period_timer_pkg::IRQ_MATCH_BIT;
            period_timer_pkg::ADDR_ENABLES: rd_data <= 8'(enable_q) << period_timer_pkg::IRQ_MATCH_BIT;
            default:                        rd_data <= 8'h00;
         endcase
      end
   end

   // Checks
   sequence run_match_s;
      control_q[period_timer_pkg::CTL_RUN_BIT] && match && tick && !wr_count;
   endsequence

   chk_match_clears_count: assert property (@(posedge mclk) disable iff (rst)
      run_match_s |=> count_q == '0 || $past(wr_count))
      else $error("count not cleared after match");

   chk_tick_increments: assert property (@(posedge mclk) disable iff (rst)
      tick && !match && !wr_count |=> count_q == $past(count_q) + COUNT_WIDTH'(1))
      else $error("count did not step on tick");

   chk_stop_holds: assert property (@(posedge mclk) disable iff (rst)
      !control_q[period_timer_pkg::CTL_RUN_BIT] && !wr_en |=> $stable(count_q) && $stable(pre_q))
      else $error("stopped timer moved");

   chk_ctl_keeps_count: assert property (@(posedge mclk) disable iff (rst)
      wr_control |=> count_q == $past(count_q) || $past(tick))
      else $error("control write changed count");

   chk_scaler_clear: assert property (@(posedge mclk) disable iff (rst)
      scaler_clr |=> pre_q == 4'h0 && post_q == '0)
      else $error("scalers not cleared by write");

   chk_match_output: assert property (@(posedge mclk) disable iff (rst)
      run_match_s |=> match_out)
      else $error("match output missing");

   chk_flag_sets: assert property (@(posedge mclk) disable iff (rst)
      post_done && tick |=> flag_q ##1 (irq == enable_q || $past(enable_q) != enable_q))
      else $error("flag not raised at postscale count");

   chk_irq_gated: assert property (@(posedge mclk) disable iff (rst)
      !enable_q && !$past(enable_q) |-> !irq)
      else $error("irq without enable");

   chk_bit7_zero: assert property (@(posedge mclk) disable iff (rst)
      rd_en && addr == period_timer_pkg::ADDR_CONTROL |=> !rd_data[7])
      else $error("control bit 7 read as one");
endmodule // period_timer

// ===== pwm_base_model.sv
// Purpose: Far-side stand-in for the PWM time base and serial shift clock user
// Assumes: Every match pulse is one PWM period boundary or one shift clock
// Notes:   Counting gives the bench a view of match events apart from the timer
module pwm_base_model (
   input  wire logic        mclk,      // Instruction clock
   input  wire logic        rst,       // Synchronous reset
   input  wire logic        match_in,  // Unscaled match from the timer
   output logic      [15:0] match_cnt  // Matches seen since reset
);
   // Each pulse restarts a PWM period and clocks the serial shifter
   always_ff @(posedge mclk) begin
      if (rst) begin
         match_cnt <= 16'h0000;
      end else if (match_in) begin
         match_cnt <= match_cnt + 16'h0001;
      end
   end
endmodule // pwm_base_model

// ===== period_timer_test.sv
// Purpose: Self-checking bench for the period match timer
// Assumes: Read data stand in the single cycle after the read strobe
// Notes:   Reads queue their expectation; a monitor compares on arrival
module period_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst, wr_en, rd_en, match_out, irq;
   logic [2:0]  addr;
   logic [7:0]  wr_data, rd_data, per;
   logic [15:0] match_cnt, m0;
   logic [7:0]  exp_q[$];
   int          error_cnt, num_checks, cyc, c0;
   int          divs[4] = '{1, 4, 16, 16};
   int          posts[5] = '{0, 1, 7, 15, 0};

   period_timer i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .match_out(match_out), .irq(irq));
   pwm_base_model i_far (.mclk(mclk), .rst(rst), .match_in(match_out), .match_cnt(match_cnt));

   // Clock and a cycle count for period measurements
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) cyc++;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      rd_en <= 1'b0;
   endtask

   // Bounded wait so a dead output cannot hang the run
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (s !== 1'b1 && n < 3000);
      if (n >= 3000) error_cnt++;
   endtask

   // Read data are only valid one cycle after the strobe
   always @(posedge mclk) begin
      if (rd_en === 1'b1) begin
         #1;
         check(rd_data, exp_q.pop_front());
      end
   end

   // Whole run is under 3000 cycles; this limit leaves ample margin
   initial begin
      #60000;
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 3'h0;
      wr_data = 8'h00;
      void'($urandom(85564));
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd(period_timer_pkg::ADDR_COUNT, 8'h00);
      rd(period_timer_pkg::ADDR_PERIOD, 8'hff);
      rd(3'h5, 8'h00);
      per = 8'($urandom_range(7, 1));
      wr(period_timer_pkg::ADDR_PERIOD, per);
      rd(period_timer_pkg::ADDR_PERIOD, per);
      wr(period_timer_pkg::ADDR_COUNT, 8'h33);
      wr(period_timer_pkg::ADDR_CONTROL, 8'hfb);
      rd(period_timer_pkg::ADDR_CONTROL, 8'h7b);
      repeat (20) @(posedge mclk);
      rd(period_timer_pkg::ADDR_COUNT, 8'h33);
      // Match spacing is (period+1) prescaled ticks for every prescale code
      for (int i = 0; i < 4; i++) begin
         wr(period_timer_pkg::ADDR_CONTROL, 8'(4 + i));
         wait_hi(match_out);
         c0 = cyc;
         wait_hi(match_out);
         check(cyc - c0, (per + 1) * divs[i]);
      end
      // Flag rises on match N+1 after a control write restarts the postscaler
      wr(period_timer_pkg::ADDR_ENABLES, 8'h02);
      wr(period_timer_pkg::ADDR_PERIOD, 8'h01);
      posts[4] = $urandom_range(15, 0);
      foreach (posts[i]) begin
         wr(period_timer_pkg::ADDR_CONTROL, 8'h00);
         wr(period_timer_pkg::ADDR_FLAGS, 8'h02);
         rd(period_timer_pkg::ADDR_FLAGS, 8'h00);
         wr(period_timer_pkg::ADDR_COUNT, 8'h00);
         m0 = match_cnt;
         wr(period_timer_pkg::ADDR_CONTROL, 8'(4 + posts[i] * 8));
         wait_hi(irq);
         check(match_cnt - m0, posts[i] + 1);
      end
      // Masked flag keeps the request low until the enable returns
      wr(period_timer_pkg::ADDR_CONTROL, 8'h00);
      wr(period_timer_pkg::ADDR_ENABLES, 8'h00);
      wr(period_timer_pkg::ADDR_FLAGS, 8'h02);
      wr(period_timer_pkg::ADDR_CONTROL, 8'h04);
      repeat (12) @(posedge mclk);
      #1;
      check(irq, 1'b0);
      rd(period_timer_pkg::ADDR_FLAGS, 8'h02);
      wr(period_timer_pkg::ADDR_ENABLES, 8'h02);
      repeat (2) @(posedge mclk);
      #1;
      check(irq, 1'b1);
      tally_and_finish();
   end
endmodule // period_timer_test
